// File: pkg/pace_cfg_pkg.sv
// Purpose: constants for the pace, battery-monitor and lead-off configuration bank
// Assumes: 32-bit avalon-mm word access, register index times four gives byte address
// Notes: reserved bits read as zero
package pace_cfg_pkg;
    // ==========================================================
    // register indices and byte addresses
    localparam logic [7:0] PACE_ROUTING_INDEX = 8'h04;
    localparam logic [7:0] BATTERY_ROUTING_INDEX = 8'h05;
    localparam logic [7:0] LEAD_OFF_INDEX = 8'h06;
    localparam int ADDR_WIDTH = 5;
    localparam logic [4:0] PACE_ROUTING_ADDR = 5'h10;
    localparam logic [4:0] BATTERY_ROUTING_ADDR = 5'h14;
    localparam logic [4:0] LEAD_OFF_ADDR = 5'h18;
    // ==========================================================
    // reset values
    localparam logic [7:0] PACE_ROUTING_RESET = 8'h00;
    localparam logic [2:0] BATTERY_ROUTING_RESET = 3'h0;
    localparam logic [4:0] LEAD_OFF_RESET = 5'h08;
    // ==========================================================
    // field positions
    localparam int PACE_TEST_MSB = 7;
    localparam int PACE_TEST_LSB = 6;
    localparam int PACE_POS_MSB = 5;
    localparam int PACE_POS_LSB = 3;
    localparam int PACE_NEG_MSB = 2;
    localparam int PACE_NEG_LSB = 0;
    localparam int BATTERY_MSB = 2;
    localparam int LEAD_OFF_MSB = 4;
    localparam int AC_METHOD_BIT = 4;
    localparam int SHUTDOWN_BIT = 3;
    localparam int DC_AC_BIT = 2;
    localparam int LEVEL_MSB = 1;
    localparam int LEVEL_LSB = 0;
    // ==========================================================
    // codes
    typedef enum logic [1:0] {
        TEST_NONE = 2'b00,
        TEST_POSITIVE = 2'b01,
        TEST_NEGATIVE = 2'b10,
        TEST_ZERO = 2'b11
    } test_select_e;
    localparam logic [2:0] INPUT_NONE = 3'h0;
    localparam logic [2:0] INPUT_LAST = 3'h6;
    localparam int INPUT_COUNT = 6;
endpackage

// File: testbench/pace_cfg_chk.sv
// Purpose: port checker for the configuration bank
// Assumes: one wait state per access, single clock
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module pace_cfg_chk (
    input wire logic clock, srst, read, write, waitrequest,
    input wire logic [4:0] address,
    input wire logic [31:0] writedata, readdata,
    input wire logic [3:0] byteenable, acTriggerLevelHot,
    input wire logic [5:0] pacePositiveInput, paceNegativeInput,
    input wire logic paceTestPositive, paceTestNegative, paceTestZero,
    input wire logic [2:0] batteryWatch, channelRoutingEnable,
    input wire logic acMethodAnalog, leadOffActive, acModeSelect
);
    // ==========================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence held_req;
        (read || write) && waitrequest ##1 (read || write);
    endsequence
    sequence lod_wr;
        write && !waitrequest && byteenable[0] && address == pace_cfg_pkg::LEAD_OFF_ADDR;
    endsequence
    a_one_wait: assert property (held_req |-> !waitrequest) else $error("missing answer");
    a_idle_nowait: assert property (!(read || write) |-> !waitrequest) else $error("idle wait");
    a_reset_vals: assert property (
        $fell(srst) |-> batteryWatch == 3'h0 && !leadOffActive && acTriggerLevelHot == 4'h1)
        else $error("bad reset");
    a_test_blocks: assert property (
        (paceTestPositive || paceTestNegative || paceTestZero)
        |-> pacePositiveInput == 6'h00 && paceNegativeInput == 6'h00) else $error("route");
    a_override_inv: assert property (
        channelRoutingEnable == ~batteryWatch) else $error("override");
    a_level_hot: assert property ($onehot(acTriggerLevelHot)) else $error("level");
    a_lod_write: assert property (
        lod_wr |=> acMethodAnalog == $past(writedata[4])
        && leadOffActive == !$past(writedata[3]) && acModeSelect == $past(writedata[2]))
        else $error("lead-off write");
    a_unmapped_zero: assert property (
        read && !waitrequest && address > 5'h18 |-> readdata == 32'h0000_0000)
        else $error("unmapped read");
endmodule
bind pace_vbat_leadoff_config_regs pace_cfg_chk i_chk (.*);
`default_nettype wire

// File: testbench/tb_pace_vbat_leadoff_config_regs.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: avalon-mm master holds until waitrequest low
// Notes: codes 111 on terminals expected unconnected
`timescale 1ns/1ps
`default_nettype none
module tb_pace_vbat_leadoff_config_regs;
    localparam logic [4:0] PA = pace_cfg_pkg::PACE_ROUTING_ADDR;
    localparam logic [4:0] BA = pace_cfg_pkg::BATTERY_ROUTING_ADDR;
    localparam logic [4:0] LA = pace_cfg_pkg::LEAD_OFF_ADDR;
    logic clock = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
    logic [4:0] address = 5'h0;
    logic [31:0] writedata = 32'h0, readdata, rdv;
    logic [3:0] byteenable = 4'hf, lvl;
    logic [5:0] pos, neg;
    logic tp, tn, tz, waitrequest, am, la, ms;
    logic [2:0] bw, cre;
    int errTotal = 0, cmpCount = 0;
    pace_vbat_leadoff_config_regs i_dut (.clock(clock), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pacePositiveInput(pos),
        .paceNegativeInput(neg), .paceTestPositive(tp), .paceTestNegative(tn),
        .paceTestZero(tz), .batteryWatch(bw), .channelRoutingEnable(cre),
        .acMethodAnalog(am), .leadOffActive(la), .acModeSelect(ms), .acTriggerLevelHot(lvl));
    initial forever #5 clock = ~clock;
    // ==========================================
    // bus and compare
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        {address, writedata, byteenable, write} <= {a, d, be, 1'b1};
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
        // settled outputs are looked at half a cycle later
        @(negedge clock);
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        {address, read} <= {a, 1'b1};
        do @(posedge clock); while (waitrequest !== 1'b0);
        rdv = readdata;
        read <= 1'b0;
        @(negedge clock);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(PA); check(rdv, 32'h00);
        rd(BA); check(rdv, 32'h00);
        rd(LA); check(rdv, 32'h08);
        check({la, lvl, cre, tp, tn, tz}, {1'b0, 4'h1, 3'h7, 3'h0});
    endtask
    task automatic t_pace();
        for (int c = 0; c < 4; c++) begin
            wr(PA, {24'h0, c[1:0], 6'h0a}, 4'hf);
            check({tz, tn, tp}, c == 0 ? 3'h0 : 3'h1 << (c - 1));
            check({pos, neg}, c == 0 ? 12'h042 : 12'h0);
        end
        for (int k = 0; k < 8; k++) begin
            wr(PA, {26'h0, k[2:0], k[2:0]}, 4'hf);
            check({pos, neg}, (k > 0 && k < 7) ? {6'h1 << (k - 1), 6'h1 << (k - 1)} : 12'h000);
            rd(PA); check(rdv, {26'h0, k[2:0], k[2:0]});
        end
    endtask
    // amplifier shutdown lives outside this bank, software keeps it
    task automatic t_battery();
        for (int k = 0; k < 8; k++) begin
            wr(BA, 32'hf8 | k, 4'hf);
            check({bw, cre}, {k[2:0], ~k[2:0]});
            rd(BA); check(rdv, k);
        end
    endtask
    task automatic t_lead();
        for (int k = 0; k < 32; k++) begin
            wr(LA, 32'he0 | k, 4'hf);
            check({am, la, ms, lvl}, {k[4], ~k[3], k[2], 4'h1 << k[1:0]});
            rd(LA); check(rdv, k);
        end
        wr(LA, 32'h0, 4'he);
        rd(LA); check(rdv, 32'h1f);
        wr(5'h1c, 32'hff, 4'hf);
        rd(5'h1c); check(rdv, 32'h0);
    endtask
    initial begin
        #200000;
        errTotal++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_pace();
        t_battery();
        t_lead();
        give_verdict();
    end
endmodule
`default_nettype wire

// File: verilog/pace_terminal_decode.sv
// Purpose: one-hot decode of a 3-bit terminal select field
// Assumes: codes above six are left unconnected
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module pace_terminal_decode (
    input wire logic [2:0] code,
    input wire logic testActive,
    output logic [5:0] inputHot
);
    // ==========================================================
    // decode
    always_comb begin
        inputHot = 6'h00;
        // test signal takes the terminal away from the inputs
        if (!testActive && code != pace_cfg_pkg::INPUT_NONE && code <= pace_cfg_pkg::INPUT_LAST) begin
            inputHot[3'(code - 3'h1)] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verilog/pace_vbat_leadoff_config_regs.sv
// Purpose: configuration bank for pace routing, battery monitor and lead-off control
// Assumes: avalon-mm slave, one wait state on every access
// Notes: analog switches are driven from the decoded outputs
//
// Contract
// R01 - pace test code 00: no test signal, pace follows positive and negative fields
// R02 - pace test codes 01, 10, 11 select positive, negative, zero test signal
// R03 - pace positive field 000 disconnects, 001 to 110 select inputs one to six
// R04 - pace negative field 000 disconnects, 001 to 110 select inputs one to six
// R05 - battery bits 0..2 enable monitoring on channels 1..3, overriding routing
// R06 - battery bits reset to zero; bits 7:3 reserved
// R07 - software must shut down the channel amplifier when monitoring is enabled
// R08 - lead-off bit 4: 0 digital ac detection, 1 analog ac detection
// R09 - lead-off bit 3: 1 shuts detection down (reset), 0 makes it active
// R10 - lead-off bit 2: 0 dc detection, 1 ac detection
// R11 - lead-off bits 1:0 select comparator trigger level one to four; 7:5 reserved
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pace_vbat_leadoff_config_regs (
    input wire logic clock,
    input wire logic srst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [5:0] pacePositiveInput,
    output logic [5:0] paceNegativeInput,
    output logic paceTestPositive,
    output logic paceTestNegative,
    output logic paceTestZero,
    output logic [2:0] batteryWatch,
    output logic [2:0] channelRoutingEnable,
    output logic acMethodAnalog,
    output logic leadOffActive,
    output logic acModeSelect,
    output logic [3:0] acTriggerLevelHot
);
    // ==========================================================
    // storage
    logic [7:0] paceInputRouting;
    logic [2:0] batteryMonitorRouting;
    logic [4:0] leadOffControl;
    logic accessDone;
    logic [1:0] testSel;

    function automatic logic is_hit(input logic [4:0] a, input logic [4:0] target);
        is_hit = (a == target);
    endfunction

    // ==========================================================
    // bus handshake: one wait cycle, answer on the second edge
    always_ff @(posedge clock) begin
        if (srst) begin
            accessDone <= 1'b0;
        end else begin
            accessDone <= (read || write) && !accessDone;
        end
    end
    assign waitrequest = (read || write) && !accessDone;

    // ==========================================================
    // register writes, low byte lane only carries data
    always_ff @(posedge clock) begin
        if (srst) begin
            paceInputRouting <= pace_cfg_pkg::PACE_ROUTING_RESET; // R01 R03 R04
        end else if (write && accessDone && byteenable[0]
                     && is_hit(address, pace_cfg_pkg::PACE_ROUTING_ADDR)) begin
            paceInputRouting <= writedata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            batteryMonitorRouting <= pace_cfg_pkg::BATTERY_ROUTING_RESET; // R06
        end else if (write && accessDone && byteenable[0]
                     && is_hit(address, pace_cfg_pkg::BATTERY_ROUTING_ADDR)) begin
            batteryMonitorRouting <= writedata[pace_cfg_pkg::BATTERY_MSB:0]; // R06
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            leadOffControl <= pace_cfg_pkg::LEAD_OFF_RESET; // R09
        end else if (write && accessDone && byteenable[0]
                     && is_hit(address, pace_cfg_pkg::LEAD_OFF_ADDR)) begin
            leadOffControl <= writedata[pace_cfg_pkg::LEAD_OFF_MSB:0]; // R11
        end
    end

    // ==========================================================
    // read data, unmapped reads as zero
    always_ff @(posedge clock) begin
        if (srst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !accessDone) begin
            if (is_hit(address, pace_cfg_pkg::PACE_ROUTING_ADDR)) begin
                readdata <= {24'h00_0000, paceInputRouting};
            end else if (is_hit(address, pace_cfg_pkg::BATTERY_ROUTING_ADDR)) begin
                readdata <= {29'h0000_0000, batteryMonitorRouting}; // R06
            end else if (is_hit(address, pace_cfg_pkg::LEAD_OFF_ADDR)) begin
                readdata <= {27'h000_0000, leadOffControl}; // R11
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // pace routing
    assign testSel = paceInputRouting[pace_cfg_pkg::PACE_TEST_MSB:pace_cfg_pkg::PACE_TEST_LSB];

    always_comb begin
        paceTestPositive = 1'b0;
        paceTestNegative = 1'b0;
        paceTestZero = 1'b0;
        case (testSel)
            pace_cfg_pkg::TEST_POSITIVE: paceTestPositive = 1'b1; // R02
            pace_cfg_pkg::TEST_NEGATIVE: paceTestNegative = 1'b1; // R02
            pace_cfg_pkg::TEST_ZERO: paceTestZero = 1'b1; // R02
            default: paceTestZero = 1'b0; // R01
        endcase
    end

    pace_terminal_decode positiveDecode (
        .code(paceInputRouting[pace_cfg_pkg::PACE_POS_MSB:pace_cfg_pkg::PACE_POS_LSB]), // R03
        .testActive(testSel != pace_cfg_pkg::TEST_NONE), // R01
        .inputHot(pacePositiveInput)
    );

    pace_terminal_decode negativeDecode (
        .code(paceInputRouting[pace_cfg_pkg::PACE_NEG_MSB:pace_cfg_pkg::PACE_NEG_LSB]), // R04
        .testActive(testSel != pace_cfg_pkg::TEST_NONE), // R01
        .inputHot(paceNegativeInput)
    );

    // ==========================================================
    // battery monitor overrides normal channel routing
    // amplifier shutdown is left to software, not enforced here
    assign batteryWatch = batteryMonitorRouting; // R05
    assign channelRoutingEnable = ~batteryMonitorRouting; // R05 R07

    // ==========================================================
    // lead-off control
    assign acMethodAnalog = leadOffControl[pace_cfg_pkg::AC_METHOD_BIT]; // R08
    assign leadOffActive = !leadOffControl[pace_cfg_pkg::SHUTDOWN_BIT]; // R09
    assign acModeSelect = leadOffControl[pace_cfg_pkg::DC_AC_BIT]; // R10

    always_comb begin
        acTriggerLevelHot = 4'h0;
        acTriggerLevelHot[leadOffControl[pace_cfg_pkg::LEVEL_MSB:pace_cfg_pkg::LEVEL_LSB]] = 1'b1; // R11
    end
endmodule
`default_nettype wire
